//--- hbi_host_port.sv
// asynchronous 8-bit host processor port with register bank and request pacing
// Operation
// - accesses only taken while chip select is low; strobes other than the address latch strobe ignored otherwise
// - separate strobes: write strobe low marks a write access
// - separate strobes: read strobe low returns register data
// - direction mode: direction high means read, low means write
// - direction mode: data strobe rising edge ends the access
// - multiplexed mode: shared lines carry address first, then data
// - data lines driven only while returning read data, else released
// - open-drain interrupt pulled low while an interrupt or, without dma pacing, a fifo request is pending
// - high reset pin holds the whole block in reset, except the pin synchronisers
// - eight-bit data; demultiplexed address on separate lines
// - fifo requests paced either by interrupt or by dma request
`timescale 1ns/1ns
`default_nettype none
module hbi_host_port #(
    parameter int DW = hbi_pkg::DATA_W,
    parameter int AW = hbi_pkg::ADDR_W,
    parameter int LW = hbi_pkg::LADDR_W
) (
    input wire logic ref_clk,                    // 250 MHz system clock
    input wire logic rst_n,                      // synchronous reset, active low
    input wire logic res_pin,                    // reset pin, active high, async
    input wire logic cs_n_pin,                   // chip select, active low
    input wire logic wr_n_or_rw,                 // write strobe or direction
    input wire logic rd_n_or_data_strobe,        // read strobe or data strobe
    input wire logic ale_pin,                    // address latch strobe
    input wire logic [LW-1:0] low_addr_lines,    // demultiplexed address
    input wire logic [DW-1:0] muxed_bus_lines_in,  // bus lines, level seen
    output logic [DW-1:0] muxed_bus_lines_out,   // bus lines, read data
    output logic muxed_bus_lines_oe,             // bus lines, drive enable
    output logic int_n_out,                      // interrupt pin level, always 0
    output logic int_n_oe,                       // interrupt pin pull-down enable
    input wire logic core_irq,                   // core interrupt pending
    input wire logic core_fifo_req,              // core fifo wants service
    input wire logic core_dma_mode,              // 1: pace fifo by dma request
    output logic dma_req,                        // request to dma controller
    output logic core_reset,                     // reset for the whole device
    output logic [1:0] bus_mode,                 // chosen bus mode
    output logic core_wr_stb,                    // one-cycle host write pulse
    output logic [AW-1:0] core_wr_addr,          // address of that write
    output logic [DW-1:0] core_wr_data,          // data of that write
    input wire logic [hbi_pkg::MEM_AW-1:0] core_rd_addr, // core read index
    output logic [DW-1:0] core_rd_data           // core read data
);
    // ======================================================================
    // pin synchronisers
    logic [hbi_pkg::SYNC_W-1:0] pins_s;
    logic res_s, cs_s, wr_s, rd_s, ale_s;
    logic [LW-1:0] laddr_s;
    logic [DW-1:0] bus_s;
    logic rst_int;

    hbi_sync #(
        .W(hbi_pkg::SYNC_W),
        .RST_VAL(hbi_pkg::SYNC_RST)
    ) u_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .pin_in({res_pin, cs_n_pin, wr_n_or_rw, rd_n_or_data_strobe, ale_pin,
                 low_addr_lines, muxed_bus_lines_in}),
        .sync_out(pins_s)
    );

    // unpack the resynchronised pins
    assign res_s = pins_s[hbi_pkg::POS_RES];
    assign cs_s = pins_s[hbi_pkg::POS_CS];
    assign wr_s = pins_s[hbi_pkg::POS_WR];
    assign rd_s = pins_s[hbi_pkg::POS_RD];
    assign ale_s = pins_s[hbi_pkg::POS_ALE];
    assign laddr_s = pins_s[hbi_pkg::POS_LADDR +: LW];
    assign bus_s = pins_s[hbi_pkg::POS_BUS +: DW];

    // either reset source holds everything but the pin synchronisers
    assign rst_int = !rst_n || res_s;
    assign core_reset = rst_int;

    // ======================================================================
    // state
    hbi_pkg::hbi_mode_type mode_ff, nxt_mode, mode_eff;
    hbi_pkg::hbi_acc_type acc_ff, nxt_acc;
    logic ale_seen_ff, nxt_ale_seen;
    logic [AW-1:0] latch_ff, nxt_latch;
    logic [AW-1:0] addr_ff, nxt_addr;
    logic [DW-1:0] wdata_ff, nxt_wdata;
    logic [DW-1:0] rdata_ff, nxt_rdata;
    logic rd_wait_ff, nxt_rd_wait;
    logic rd_valid_ff, nxt_rd_valid;
    logic wr_stb_ff, nxt_wr_stb;
    logic int_ff, nxt_int;
    logic dma_ff, nxt_dma;
    logic [AW-1:0] addr_eff;
    logic sep_strobes, rd_act, wr_act, mem_we;
    logic [DW-1:0] mem_a_data;

    // ======================================================================
    // mode chosen from the latch strobe at the first access
    always_comb
    begin
        mode_eff = mode_ff;
        if (mode_ff == hbi_pkg::MODE_WAIT)
        begin
            if (ale_s)
                mode_eff = hbi_pkg::MODE_DEMUX_DIR;
            else if (ale_seen_ff)
                mode_eff = hbi_pkg::MODE_MUX;
            else
                mode_eff = hbi_pkg::MODE_DEMUX_SEP;
        end
    end

    // strobe decode; nothing counts while chip select is high
    always_comb
    begin
        sep_strobes = (mode_eff != hbi_pkg::MODE_DEMUX_DIR);
        if (sep_strobes)
        begin
            rd_act = !cs_s && !rd_s && wr_s;
            wr_act = !cs_s && !wr_s;
        end
        else
        begin
            rd_act = !cs_s && !rd_s && wr_s;
            wr_act = !cs_s && !rd_s && !wr_s;
        end
    end

    // address: latch in shared mode, dedicated lines otherwise
    always_comb
    begin
        if (mode_eff == hbi_pkg::MODE_MUX)
            addr_eff = ale_s ? bus_s : latch_ff;
        else
            addr_eff = {hbi_pkg::LADDR_PAD, laddr_s};
    end

    // ======================================================================
    // address latch and mode memory
    always_comb
    begin
        nxt_latch = ale_s ? bus_s : latch_ff;
        nxt_ale_seen = ale_seen_ff || ale_s;
        nxt_mode = mode_ff;
        if (mode_ff == hbi_pkg::MODE_WAIT && (rd_act || wr_act))
            nxt_mode = mode_eff;
        if (rst_int)
        begin
            nxt_latch = hbi_pkg::ADDR_RST;
            nxt_ale_seen = 1'b0;
            nxt_mode = hbi_pkg::MODE_WAIT;
        end
    end
    always_ff @(posedge ref_clk)
    begin
        latch_ff <= nxt_latch;
        ale_seen_ff <= nxt_ale_seen;
        mode_ff <= nxt_mode;
    end

    // ======================================================================
    // access sequencer; write data committed only when the access ends,
    // so a slow host can settle the lines while the strobe is low
    always_comb
    begin
        nxt_acc = acc_ff;
        nxt_addr = addr_ff;
        nxt_wdata = wdata_ff;
        nxt_rdata = rdata_ff;
        nxt_rd_wait = 1'b0;
        nxt_rd_valid = rd_valid_ff;
        nxt_wr_stb = 1'b0;
        mem_we = 1'b0;
        case (acc_ff)
            hbi_pkg::ACC_IDLE:
            begin
                nxt_rd_valid = 1'b0;
                if (rd_act)
                begin
                    nxt_acc = hbi_pkg::ACC_READ;
                    nxt_addr = addr_eff;
                    nxt_rd_wait = 1'b1;
                end
                else if (wr_act)
                begin
                    nxt_acc = hbi_pkg::ACC_WRITE;
                    nxt_addr = addr_eff;
                    nxt_wdata = bus_s;
                end
            end
            hbi_pkg::ACC_READ:
            begin
                if (rd_wait_ff)
                begin
                    nxt_rdata = mem_a_data;
                    nxt_rd_valid = 1'b1;
                end
                if (!rd_act)
                begin
                    nxt_acc = hbi_pkg::ACC_IDLE;
                    nxt_rd_valid = 1'b0;
                end
            end
            hbi_pkg::ACC_WRITE:
            begin
                if (wr_act)
                    nxt_wdata = bus_s;
                else
                begin
                    mem_we = 1'b1;
                    nxt_wr_stb = 1'b1;
                    nxt_acc = hbi_pkg::ACC_IDLE;
                end
            end
            default:
                nxt_acc = hbi_pkg::ACC_IDLE;
        endcase
        if (rst_int)
        begin
            nxt_acc = hbi_pkg::ACC_IDLE;
            nxt_addr = hbi_pkg::ADDR_RST;
            nxt_wdata = hbi_pkg::DATA_RST;
            nxt_rdata = hbi_pkg::DATA_RST;
            nxt_rd_valid = 1'b0;
            nxt_wr_stb = 1'b0;
            mem_we = 1'b0;
        end
    end
    always_ff @(posedge ref_clk)
    begin
        acc_ff <= nxt_acc;
        addr_ff <= nxt_addr;
        wdata_ff <= nxt_wdata;
        rdata_ff <= nxt_rdata;
        rd_wait_ff <= nxt_rd_wait;
        rd_valid_ff <= nxt_rd_valid;
        wr_stb_ff <= nxt_wr_stb;
    end

    // ======================================================================
    // register bank; upper address bits alias onto the bank
    hbi_regmem #(
        .DEPTH(hbi_pkg::MEM_DEPTH),
        .AW(hbi_pkg::MEM_AW),
        .DW(DW)
    ) u_mem (
        .ref_clk(ref_clk),
        .rst_n(!rst_int),
        .wr_en(mem_we),
        .wr_addr(addr_ff[hbi_pkg::MEM_AW-1:0]),
        .wr_data(wdata_ff),
        .a_addr(nxt_addr[hbi_pkg::MEM_AW-1:0]), // next index, so data is fresh at load
        .a_data(mem_a_data),
        .b_addr(core_rd_addr),
        .b_data(core_rd_data)
    );

    // ======================================================================
    // request pacing: interrupt line or dma request
    always_comb
    begin
        nxt_int = core_irq || (core_fifo_req && !core_dma_mode);
        nxt_dma = core_fifo_req && core_dma_mode;
        if (rst_int)
        begin
            nxt_int = 1'b0;
            nxt_dma = 1'b0;
        end
    end
    always_ff @(posedge ref_clk)
    begin
        int_ff <= nxt_int;
        dma_ff <= nxt_dma;
    end

    // ======================================================================
    // pin drivers; open drain only ever pulls low
    assign muxed_bus_lines_out = rdata_ff;
    assign muxed_bus_lines_oe = (acc_ff == hbi_pkg::ACC_READ) && rd_valid_ff;
    assign int_n_out = 1'b0;
    assign int_n_oe = int_ff;
    assign dma_req = dma_ff;
    assign bus_mode = mode_ff;
    assign core_wr_stb = wr_stb_ff;
    assign core_wr_addr = addr_ff;
    assign core_wr_data = wdata_ff;

    // ======================================================================
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst_int);

    a_cs_blocks_access: assert property ((acc_ff == hbi_pkg::ACC_IDLE) && cs_s
        |=> acc_ff == hbi_pkg::ACC_IDLE) else $error("access taken without chip select");
    a_wr_strobe_write: assert property ((acc_ff == hbi_pkg::ACC_IDLE) && sep_strobes
        && !cs_s && !wr_s |=> acc_ff == hbi_pkg::ACC_WRITE)
        else $error("write strobe not taken as write");
    a_rd_strobe_data: assert property ((acc_ff == hbi_pkg::ACC_IDLE) && rd_act
        ##1 rd_act [*2] |=> muxed_bus_lines_oe && muxed_bus_lines_out == mem_a_data)
        else $error("read data not returned");
    a_dir_read_sel: assert property ((acc_ff == hbi_pkg::ACC_IDLE) && !sep_strobes
        && !cs_s && !rd_s && wr_s |=> acc_ff == hbi_pkg::ACC_READ)
        else $error("direction high not a read");
    a_strobe_end_commit: assert property ((acc_ff == hbi_pkg::ACC_WRITE) && !wr_act
        |=> core_wr_stb && core_wr_data == $past(wdata_ff) ##1 !core_wr_stb)
        else $error("write end not committed once");
    a_bus_drive_read: assert property (muxed_bus_lines_oe
        |-> $past(rd_act) && $past(acc_ff) == hbi_pkg::ACC_READ)
        else $error("bus driven outside read");
    a_latch_hold_low: assert property (!ale_s |=> latch_ff == $past(latch_ff))
        else $error("latch moved while strobe low");
    a_mode_hold_sel: assert property ((mode_ff != hbi_pkg::MODE_WAIT) |=> $stable(mode_ff))
        else $error("bus mode changed after selection");
    a_int_pending_out: assert property (core_irq |=> int_n_oe && !int_n_out)
        else $error("pending interrupt not driven");
    a_dma_pacing_sel: assert property (core_fifo_req && core_dma_mode && !core_irq
        |=> dma_req && !int_n_oe) else $error("dma pacing wrong");
endmodule
`default_nettype wire

//--- hbi_pkg.sv
// constants and types shared by the host bus interface files
package hbi_pkg;
    // ======================================================================
    // widths
    localparam int DATA_W = 8;          // host data path
    localparam int ADDR_W = 8;          // multiplexed address width
    localparam int LADDR_W = 4;         // dedicated address lines
    localparam int MEM_AW = 4;          // register bank index width
    localparam int MEM_DEPTH = 16;      // register bank entries
    localparam int SYNC_STAGES = 2;     // flops per pin synchroniser

    // ======================================================================
    // synchroniser vector layout and idle values
    localparam int SYNC_W = 17;
    localparam int POS_RES = 16;
    localparam int POS_CS = 15;
    localparam int POS_WR = 14;
    localparam int POS_RD = 13;
    localparam int POS_ALE = 12;
    localparam int POS_LADDR = 8;
    localparam int POS_BUS = 0;
    localparam logic [SYNC_W-1:0] SYNC_RST = 17'h0e000; // chip select, write and read strobes idle high; latch strobe idle low

    // ======================================================================
    // reset values
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_RST = 8'h00;
    localparam logic [LADDR_W-1:0] LADDR_PAD = 4'h0;
    localparam logic [DATA_W-1:0] MEM_RST = 8'h00;

    // ======================================================================
    // bus mode, chosen once per reset
    typedef enum logic [1:0] {
        MODE_WAIT = 2'b00,      // no access seen yet
        MODE_MUX = 2'b01,       // shared lines, separate strobes
        MODE_DEMUX_SEP = 2'b10, // address lines, separate strobes
        MODE_DEMUX_DIR = 2'b11  // address lines, direction plus strobe
    } hbi_mode_type;

    // access sequencer
    typedef enum logic [1:0] {
        ACC_IDLE = 2'b00,
        ACC_READ = 2'b01,
        ACC_WRITE = 2'b10
    } hbi_acc_type;
endpackage

//--- hbi_sync.sv
// two-flop synchroniser bank for asynchronous pins
`timescale 1ns/1ns
`default_nettype none
module hbi_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic ref_clk,          // system clock
    input wire logic rst_n,            // synchronous reset, active low
    input wire logic [W-1:0] pin_in,   // raw asynchronous inputs
    output logic [W-1:0] sync_out      // resynchronised inputs
);
    // ======================================================================
    // one chain per bit; first stage feeds only the second
    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            logic meta_ff;
            logic safe_ff;
            logic nxt_meta;
            logic nxt_safe;
            // next values, reset to the idle level
            always_comb
            begin
                nxt_meta = rst_n ? pin_in[i] : RST_VAL[i];
                nxt_safe = rst_n ? meta_ff : RST_VAL[i];
            end
            always_ff @(posedge ref_clk)
            begin
                meta_ff <= nxt_meta;
                safe_ff <= nxt_safe;
            end
            assign sync_out[i] = safe_ff;
        end
    endgenerate
endmodule
`default_nettype wire

//--- hbi_regmem.sv
// small register bank with one write port and two registered read ports
`timescale 1ns/1ns
`default_nettype none
module hbi_regmem #(
    parameter int DEPTH = hbi_pkg::MEM_DEPTH,
    parameter int AW = hbi_pkg::MEM_AW,
    parameter int DW = hbi_pkg::DATA_W
) (
    input wire logic ref_clk,          // system clock
    input wire logic rst_n,            // synchronous reset, active low
    input wire logic wr_en,            // write strobe
    input wire logic [AW-1:0] wr_addr, // write index
    input wire logic [DW-1:0] wr_data, // write data
    input wire logic [AW-1:0] a_addr,  // host read index
    output logic [DW-1:0] a_data,      // host read data, registered
    input wire logic [AW-1:0] b_addr,  // core read index
    output logic [DW-1:0] b_data       // core read data, registered
);
    logic [DW-1:0] mem_ff [DEPTH];
    logic [DW-1:0] a_ff;
    logic [DW-1:0] b_ff;
    logic [DW-1:0] nxt_a;
    logic [DW-1:0] nxt_b;

    // ======================================================================
    // storage, one entry per generate step
    genvar i;
    generate
        for (i = 0; i < DEPTH; i++)
        begin : g_ent
            logic [DW-1:0] nxt_ent;
            always_comb
            begin
                nxt_ent = mem_ff[i];
                if (!rst_n)
                    nxt_ent = hbi_pkg::MEM_RST;
                else if (wr_en && (wr_addr == AW'(i)))
                    nxt_ent = wr_data;
            end
            always_ff @(posedge ref_clk)
            begin
                mem_ff[i] <= nxt_ent;
            end
        end
    endgenerate

    // ======================================================================
    // read ports: one cycle from index to data
    always_comb
    begin
        nxt_a = rst_n ? mem_ff[a_addr] : hbi_pkg::MEM_RST;
        nxt_b = rst_n ? mem_ff[b_addr] : hbi_pkg::MEM_RST;
    end
    always_ff @(posedge ref_clk)
    begin
        a_ff <= nxt_a;
        b_ff <= nxt_b;
    end
    assign a_data = a_ff;
    assign b_data = b_ff;
endmodule
`default_nettype wire

//--- hbi_host_model.sv
// host processor model driving the asynchronous 8-bit bus pins
`timescale 1ns/1ns
`default_nettype none
module hbi_host_model (
    input wire logic ref_clk,        // system clock
    output logic cs_n,               // chip select, active low
    output logic wr_rw,              // write strobe or direction
    output logic rd_ds,              // read strobe or data strobe
    output logic ale,                // address latch strobe
    output logic [3:0] laddr,        // dedicated address lines
    output logic [7:0] bus_lvl,      // resolved level of the bus lines
    input wire logic [7:0] dut_out,  // block read data
    input wire logic dut_oe          // block drive enable
);
    logic [7:0] h_dat;
    logic h_oe;
    logic [7:0] last_lvl;

    // ======================================================================
    // bus resolution: no pull resistor, so a released bus keeps flipping
    always_comb
    begin
        if (dut_oe && h_oe)
            bus_lvl = 8'hxx;
        else if (dut_oe)
            bus_lvl = dut_out;
        else if (h_oe)
            bus_lvl = h_dat;
        else
            bus_lvl = ~last_lvl;
    end

    // remembers the level for the floating pattern
    always @(posedge ref_clk)
        last_lvl <= bus_lvl;

    initial
    begin
        cs_n = 1'b1;
        wr_rw = 1'b1;
        rd_ds = 1'b1;
        ale = 1'b0;
        laddr = 4'h0;
        h_dat = 8'h00;
        h_oe = 1'b0;
        last_lvl = 8'h00;
    end

    // ======================================================================
    // one byte access; strobes held long enough for the two-flop sync path
    task automatic access(input bit sel, input bit rd, input bit dir, input bit mux,
            input bit ale_on, input logic [7:0] addr, input logic [7:0] wdat,
            output logic [7:0] rdat, output bit saw_oe);
        saw_oe = 1'b0;
        @(posedge ref_clk);
        if (mux)
        begin
            ale <= 1'b1;
            h_oe <= 1'b1;
            h_dat <= addr;
            repeat (4) @(posedge ref_clk);
            ale <= 1'b0;
            repeat (4) @(posedge ref_clk); // address held past the latch fall
        end
        cs_n <= ~sel;
        laddr <= addr[3:0];
        ale <= ale_on;
        h_oe <= ~rd;
        h_dat <= wdat;
        if (dir)
        begin
            wr_rw <= rd;
            rd_ds <= 1'b0;
        end
        else if (rd)
            rd_ds <= 1'b0;
        else
            wr_rw <= 1'b0;
        repeat (12)
        begin
            @(posedge ref_clk);
            if (dut_oe === 1'b1)
                saw_oe = 1'b1;
        end
        rdat = bus_lvl;
        rd_ds <= 1'b1;
        cs_n <= 1'b1;
        if (!dir)
            wr_rw <= 1'b1;
        @(posedge ref_clk);
        wr_rw <= 1'b1; // direction kept until the strobe end is past
        h_oe <= 1'b0;
        ale <= 1'b0;
        repeat (8) @(posedge ref_clk);
    endtask
endmodule
`default_nettype wire

//--- test_hbi_host_port.sv
// self-checking testbench for the host bus interface
`timescale 1ns/1ns
`default_nettype none
module test_hbi_host_port;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic res_pin = 1'b0;
    logic core_irq = 1'b0;
    logic core_fifo_req = 1'b0;
    logic core_dma_mode = 1'b0;
    logic [3:0] core_rd_addr = 4'h0;
    wire logic cs_n, wr_rw, rd_ds, ale, oe, int_n_out, int_n_oe, dma_req, core_reset, wr_stb;
    wire logic [3:0] laddr;
    wire logic [7:0] bus_in, bus_out, wr_addr, wr_data, rd_data;
    wire logic [1:0] bus_mode;
    int num_errors = 0;
    int n_tests = 0;
    int cyc = 0;
    int stb_cnt = 0;
    logic [7:0] wa, wd, rdat;
    bit seen;

    always #2 ref_clk = ~ref_clk;

    hbi_host_port dut (.ref_clk(ref_clk), .rst_n(rst_n), .res_pin(res_pin), .cs_n_pin(cs_n),
        .wr_n_or_rw(wr_rw), .rd_n_or_data_strobe(rd_ds), .ale_pin(ale),
        .low_addr_lines(laddr), .muxed_bus_lines_in(bus_in), .muxed_bus_lines_out(bus_out),
        .muxed_bus_lines_oe(oe), .int_n_out(int_n_out), .int_n_oe(int_n_oe),
        .core_irq(core_irq), .core_fifo_req(core_fifo_req), .core_dma_mode(core_dma_mode),
        .dma_req(dma_req), .core_reset(core_reset), .bus_mode(bus_mode),
        .core_wr_stb(wr_stb), .core_wr_addr(wr_addr), .core_wr_data(wr_data),
        .core_rd_addr(core_rd_addr), .core_rd_data(rd_data));

    hbi_host_model host (.ref_clk(ref_clk), .cs_n(cs_n), .wr_rw(wr_rw), .rd_ds(rd_ds),
        .ale(ale), .laddr(laddr), .bus_lvl(bus_in), .dut_out(bus_out), .dut_oe(oe));

    // ======================================================================
    // write pulse monitor, counts pulses and keeps the last address and data
    always @(posedge ref_clk)
    begin
        if (wr_stb === 1'b1)
        begin
            stb_cnt++;
            wa = wr_addr;
            wd = wr_data;
        end
    end

    // cuts a hung run short
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            num_errors++;
            test_done();
        end
    end

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (4) @(posedge ref_clk);
        check("core_reset", 8'h01, {7'h00, core_reset});
        check("oe", 8'h00, {7'h00, oe});
        check("int_oe", 8'h00, {7'h00, int_n_oe});
        check("mode", 8'h00, {6'h00, bus_mode});
        rst_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
    endtask

    // ======================================================================
    // demultiplexed, separate strobes; cs high refused; mode held
    task automatic t_demux();
        host.access(1, 0, 0, 0, 0, 8'h05, 8'ha5, rdat, seen);
        check("stb count", 8'h01, 8'(stb_cnt));
        check("wr addr", 8'h05, wa);
        check("wr data", 8'ha5, wd);
        check("mode", 8'h02, {6'h00, bus_mode});
        host.access(0, 0, 0, 0, 0, 8'h05, 8'h3c, rdat, seen);
        check("stb count cs high", 8'h01, 8'(stb_cnt));
        host.access(1, 1, 0, 0, 0, 8'h05, 8'h00, rdat, seen);
        check("read data", 8'ha5, rdat);
        check("oe during read", 8'h01, {7'h00, seen});
        check("oe idle", 8'h00, {7'h00, oe});
        host.access(0, 1, 0, 0, 0, 8'h05, 8'h00, rdat, seen);
        check("oe read cs high", 8'h00, {7'h00, seen});
        core_rd_addr <= 4'h5;
        repeat (2) @(posedge ref_clk);
        check("core read", 8'ha5, rd_data);
        host.access(1, 0, 0, 1, 0, 8'h09, 8'h77, rdat, seen);
        check("mode kept", 8'h02, {6'h00, bus_mode});
        host.access(1, 1, 0, 0, 0, 8'h05, 8'h00, rdat, seen);
        check("read after other addr", 8'ha5, rdat);
        $display("test demux done");
    endtask

    // reset pin holds everything in reset and forgets the mode
    task automatic t_res_pin();
        core_irq <= 1'b1;
        res_pin <= 1'b1;
        repeat (4) @(posedge ref_clk);
        check("res core_reset", 8'h01, {7'h00, core_reset});
        check("res mode", 8'h00, {6'h00, bus_mode});
        check("res int", 8'h00, {7'h00, int_n_oe});
        res_pin <= 1'b0;
        core_irq <= 1'b0;
        repeat (5) @(posedge ref_clk);
        check("res released", 8'h00, {7'h00, core_reset});
        $display("test reset pin done");
    endtask

    // multiplexed: address latched on the latch strobe fall, then data
    task automatic t_mux();
        host.access(1, 0, 0, 1, 0, 8'h3b, 8'hc4, rdat, seen);
        check("mux mode", 8'h01, {6'h00, bus_mode});
        check("mux wr addr", 8'h3b, wa);
        check("mux wr data", 8'hc4, wd);
        host.access(1, 1, 0, 1, 0, 8'h3b, 8'h00, rdat, seen);
        check("mux read", 8'hc4, rdat);
        $display("test mux done");
    endtask

    // direction plus data strobe, latch strobe high on the first access
    task automatic t_dir();
        do_reset();
        host.access(1, 0, 1, 0, 1, 8'h02, 8'h5a, rdat, seen);
        check("dir mode", 8'h03, {6'h00, bus_mode});
        check("dir wr addr", 8'h02, wa);
        check("dir wr data", 8'h5a, wd);
        host.access(1, 1, 1, 0, 0, 8'h02, 8'h00, rdat, seen);
        check("dir read", 8'h5a, rdat);
        check("dir oe idle", 8'h00, {7'h00, oe});
        $display("test direction done");
    endtask

    // interrupt line and dma pacing of fifo requests
    task automatic t_irq();
        core_irq <= 1'b1;
        repeat (2) @(posedge ref_clk);
        check("int pull", 8'h01, {7'h00, int_n_oe});
        check("int level", 8'h00, {7'h00, int_n_out});
        core_irq <= 1'b0;
        core_fifo_req <= 1'b1;
        repeat (2) @(posedge ref_clk);
        check("fifo int", 8'h01, {7'h00, int_n_oe});
        check("fifo no dma", 8'h00, {7'h00, dma_req});
        core_dma_mode <= 1'b1;
        repeat (2) @(posedge ref_clk);
        check("dma int off", 8'h00, {7'h00, int_n_oe});
        check("dma req", 8'h01, {7'h00, dma_req});
        core_fifo_req <= 1'b0;
        repeat (2) @(posedge ref_clk);
        check("int idle", 8'h00, {7'h00, int_n_oe});
        $display("test interrupt done");
    endtask

    task automatic test_done();
        $display("checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ======================================================================
    // main sequence
    initial
    begin
        do_reset();
        t_demux();
        t_res_pin();
        t_mux();
        t_dir();
        t_irq();
        test_done();
    end
endmodule
`default_nettype wire
